// file: ats_pkg.sv
// constants and state types for the timer-triggered conversion sequencer
package ats_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_MODE_A = 8'h00;
  localparam logic [7:0] OFF_MODE_B = 8'h04;
  localparam logic [7:0] OFF_TCTRL = 8'h08;
  localparam logic [7:0] OFF_TCOUNT = 8'h0c;
  localparam logic [7:0] OFF_CMP0 = 8'h10;
  localparam logic [7:0] OFF_RES0 = 8'h20;
  // conv_mode_reg_a fields
  localparam int MA_CHAN_LSB = 0;
  localparam int MA_BUF4 = 3;
  localparam int MA_SCAN = 4;
  localparam int MA_BUSY = 6;
  localparam int MA_EN = 7;
  // conv_mode_reg_b fields
  localparam int MB_FOUR = 0;
  // timer_control_reg fields
  localparam int TC_CE = 0;
  localparam int TC_OST = 1;
  // reset values, counts and the bus transfer-type bit
  localparam logic [15:0] TMR_MAX = 16'hffff;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [3:0] LOWER_CNT = 4'h4;
  localparam logic [3:0] BUF4_CNT = 4'h4;
  localparam logic [2:0] RUNS_ONESHOT = 3'h4;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } ats_state_t;

  typedef struct packed {
    logic [2:0] clr_sync;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic en;
    logic [2:0] chan;
    logic buf4;
    logic scan;
    logic four_trig;
    logic one_shot;
    logic running;
    logic [15:0] tcount;
    logic [3:0][15:0] cmp;
    logic [3:0] match;
    logic [7:0][9:0] res;
    ats_state_t st;
    logic [3:0] cnt;
    logic [2:0] dest;
    logic internal;
    logic cs;
    logic lock;
    logic [2:0] run_cnt;
    logic conv_start;
    logic [2:0] conv_chan;
    logic conv_abort;
    logic irq;
  } ats_regs_t;
endpackage

// file: ats_sequencer.sv
// timer-triggered conversion sequencer with its trigger timer and bus slave
`timescale 1ns/1ps
module ats_sequencer
  import ats_pkg::*;
(
  input wire logic i_clock, // 10 MHz clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_hsel, // slave select
  input wire logic [31:0] i_haddr, // address
  input wire logic [1:0] i_htrans, // transfer type
  input wire logic i_hwrite, // write when high
  input wire logic [2:0] i_hsize, // transfer size, word only
  input wire logic [31:0] i_hwdata, // write data
  input wire logic i_hready, // bus ready
  input wire logic i_timer_clear_pin, // timer clear pin, asynchronous
  input wire logic i_conv_done, // converter finished all bit trials
  input wire logic [9:0] i_conv_result, // result, valid with done
  output logic [31:0] o_hrdata, // read data
  output logic o_hreadyout, // slave ready
  output logic o_hresp, // response, always okay
  output logic o_conv_start, // start pulse to converter
  output logic [2:0] o_conv_chan, // analog input to convert
  output logic o_conv_abort, // abort pulse to converter
  output logic o_in_progress, // sequence in progress flag
  output logic o_conversion_done_irq // done event pulse
);

  localparam ats_regs_t REGS_RST = '{
    clr_sync: 3'h0, wr_pend: 1'b0, wr_addr: 8'h00, hrdata: 32'h0,
    hready: 1'b1, hresp: 1'b0, en: 1'b0, chan: 3'h0, buf4: 1'b0,
    scan: 1'b0, four_trig: 1'b0, one_shot: 1'b0, running: 1'b0,
    tcount: 16'h0000, cmp: {4{CMP_RST}}, match: 4'h0, res: '0,
    st: ST_OFF, cnt: 4'h0, dest: 3'h0, internal: 1'b0, cs: 1'b0,
    lock: 1'b0, run_cnt: 3'h0, conv_start: 1'b0, conv_chan: 3'h0,
    conv_abort: 1'b0, irq: 1'b0
  };

  ats_regs_t s_r;
  ats_regs_t s_nxt;

  // word-aligned byte offset of a bus address
  function automatic logic [7:0] word_off(input logic [31:0] a);
    return {a[7:2], 2'b00};
  endfunction

  logic clr_edge;
  logic wr_mode_a;
  logic wr_mode_b;
  logic wr_tctrl;
  logic en_off_wr;

  // third stage only feeds edge detection; first stage feeds second only
  assign clr_edge = s_r.clr_sync[1] & ~s_r.clr_sync[2];
  assign wr_mode_a = s_r.wr_pend && s_r.wr_addr == OFF_MODE_A;
  assign wr_mode_b = s_r.wr_pend && s_r.wr_addr == OFF_MODE_B;
  assign wr_tctrl = s_r.wr_pend && s_r.wr_addr == OFF_TCTRL;
  assign en_off_wr = wr_mode_a && !i_hwdata[MA_EN];

  always_comb begin
    logic [7:0] a;
    logic trig;
    logic [1:0] k;
    logic [2:0] ch;
    logic [2:0] dst;
    logic [3:0] cn;
    logic [3:0] total;
    logic [2:0] rc;
    a = word_off(i_haddr);
    trig = 1'b0;
    k = 2'h0;
    ch = 3'h0;
    dst = 3'h0;
    cn = s_r.cnt + 4'h1;
    total = 4'h1;
    rc = 3'h0;
    s_nxt = s_r;
    s_nxt.conv_start = 1'b0;
    s_nxt.conv_abort = 1'b0;
    s_nxt.irq = 1'b0;
    s_nxt.clr_sync = {s_r.clr_sync[1:0], i_timer_clear_pin};

    // bus address phase: capture writes, prepare read data
    s_nxt.hready = 1'b1;
    s_nxt.hresp = 1'b0;
    s_nxt.wr_pend = i_hsel && i_htrans[1] && i_hready && i_hwrite;
    s_nxt.wr_addr = a;
    s_nxt.hrdata = 32'h0;
    if (i_hsel && (i_htrans & HTRANS_NONSEQ_BIT) != 2'h0 && i_hready &&
        !i_hwrite) begin
      if (a == OFF_MODE_A) begin
        s_nxt.hrdata[MA_CHAN_LSB +: 3] = s_r.chan;
        s_nxt.hrdata[MA_BUF4] = s_r.buf4;
        s_nxt.hrdata[MA_SCAN] = s_r.scan;
        s_nxt.hrdata[MA_BUSY] = s_r.cs;
        s_nxt.hrdata[MA_EN] = s_r.en;
      end else if (a == OFF_MODE_B) begin
        s_nxt.hrdata[MB_FOUR] = s_r.four_trig;
      end else if (a == OFF_TCTRL) begin
        s_nxt.hrdata[TC_CE] = s_r.running;
        s_nxt.hrdata[TC_OST] = s_r.one_shot;
      end else if (a == OFF_TCOUNT) begin
        s_nxt.hrdata[15:0] = s_r.tcount;
      end else if (a[7:4] == OFF_CMP0[7:4]) begin
        s_nxt.hrdata[15:0] = s_r.cmp[a[3:2]];
      end else if (a[7:5] == OFF_RES0[7:5]) begin
        s_nxt.hrdata[9:0] = s_r.res[a[4:2]];
      end
    end

    // trigger timer and its compare matches
    for (int i = 0; i < 4; i++) begin
      s_nxt.match[i] = s_r.running && s_r.tcount == s_r.cmp[i];
    end
    if (s_r.running) begin
      if (s_r.tcount == TMR_MAX) begin
        s_nxt.tcount = 16'h0000;
        s_nxt.running = !s_r.one_shot;
      end else begin
        s_nxt.tcount = s_r.tcount + 16'h0001;
      end
    end

    // trigger pick: match 0 only, or lowest index of any match
    if (s_r.four_trig) begin
      trig = s_r.match != 4'h0;
      k = s_r.match[0] ? 2'd0 : s_r.match[1] ? 2'd1 :
          s_r.match[2] ? 2'd2 : 2'd3;
    end else begin
      trig = s_r.match[0];
    end
    if (s_r.scan) begin
      ch = s_r.four_trig ? {1'b0, k} : s_r.cnt[2:0];
      dst = ch;
      if (s_r.four_trig && {1'b0, k} > s_r.chan) begin
        trig = 1'b0;
      end
      total = {1'b0, s_r.chan} + 4'h1;
    end else begin
      ch = {1'b0, s_r.chan[1:0]};
      if (s_r.buf4) begin
        dst = s_r.four_trig ? {1'b0, k} : s_r.cnt[2:0];
        total = BUF4_CNT;
      end else begin
        dst = ch;
      end
    end
    rc = (s_r.run_cnt == RUNS_ONESHOT) ? s_r.run_cnt : s_r.run_cnt + 3'h1;

    case (s_r.st)
      ST_OFF: begin
        s_nxt.cnt = 4'h0;
      end
      ST_WAIT: begin
        if (trig && !s_r.lock) begin
          s_nxt.st = ST_CONV;
          s_nxt.conv_start = 1'b1;
          s_nxt.conv_chan = ch;
          s_nxt.dest = dst;
          s_nxt.internal = 1'b0;
          s_nxt.cs = 1'b1;
        end
      end
      ST_CONV: begin
        if (i_conv_done) begin
          s_nxt.res[s_r.dest] = i_conv_result;
          if (!s_r.internal) begin
            s_nxt.run_cnt = rc;
          end
          if (s_r.scan && cn >= LOWER_CNT && cn < total) begin
            s_nxt.conv_start = 1'b1;
            s_nxt.conv_chan = cn[2:0];
            s_nxt.dest = cn[2:0];
            s_nxt.cnt = cn;
            s_nxt.internal = 1'b1;
          end else if (cn == total) begin
            s_nxt.irq = 1'b1;
            s_nxt.cs = 1'b0;
            s_nxt.cnt = 4'h0;
            s_nxt.st = ST_WAIT;
            // one-shot runs convert once per run; 1-buffer 4-trigger four
            s_nxt.lock = s_r.one_shot && !(s_r.four_trig && !s_r.buf4 &&
                         !s_r.scan && rc != RUNS_ONESHOT);
          end else begin
            s_nxt.cnt = cn;
            s_nxt.st = ST_WAIT;
          end
        end
      end
      default: begin
        s_nxt.st = ST_OFF;
      end
    endcase

    // data phase writes, which override the sequencer
    if (wr_mode_a || wr_mode_b) begin
      if (s_r.st == ST_CONV && !i_conv_done) begin
        s_nxt.conv_abort = 1'b1;
      end
      s_nxt.conv_start = 1'b0;
      s_nxt.cnt = 4'h0;
      s_nxt.cs = 1'b0;
      s_nxt.st = s_r.en ? ST_WAIT : ST_OFF;
    end
    if (wr_mode_a) begin
      s_nxt.chan = i_hwdata[MA_CHAN_LSB +: 3];
      s_nxt.buf4 = i_hwdata[MA_BUF4];
      s_nxt.scan = i_hwdata[MA_SCAN];
      s_nxt.en = i_hwdata[MA_EN];
      s_nxt.st = i_hwdata[MA_EN] ? ST_WAIT : ST_OFF;
      if (en_off_wr) begin
        s_nxt.irq = 1'b0;
      end
    end
    if (wr_mode_b) begin
      s_nxt.four_trig = i_hwdata[MB_FOUR];
    end
    if (s_r.wr_pend && s_r.wr_addr[7:4] == OFF_CMP0[7:4]) begin
      s_nxt.cmp[s_r.wr_addr[3:2]] = i_hwdata[15:0];
    end
    if (wr_tctrl) begin
      s_nxt.one_shot = i_hwdata[TC_OST];
      if (!i_hwdata[TC_CE]) begin
        s_nxt.running = 1'b0;
      end
    end
    if (clr_edge || (wr_tctrl && i_hwdata[TC_CE])) begin
      s_nxt.tcount = 16'h0000;
      s_nxt.running = 1'b1;
      s_nxt.match = 4'h0;
      s_nxt.lock = 1'b0;
      s_nxt.run_cnt = 3'h0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_r <= REGS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_hrdata = s_r.hrdata;
  assign o_hreadyout = s_r.hready;
  assign o_hresp = s_r.hresp;
  assign o_conv_start = s_r.conv_start;
  assign o_conv_chan = s_r.conv_chan;
  assign o_conv_abort = s_r.conv_abort;
  assign o_in_progress = s_r.cs;
  assign o_conversion_done_irq = s_r.irq;

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  AST_OST_STOP: assert property (
    s_r.running && s_r.one_shot && s_r.tcount == TMR_MAX && !clr_edge &&
    !wr_tctrl |=> !s_r.running && s_r.tcount == 16'h0000)
    else $error("one-shot timer did not stop at zero");

  AST_OST_QUIET: assert property (
    !s_r.running && !clr_edge && !wr_tctrl
    |=> $stable(s_r.tcount) ##1 s_r.match == 4'h0)
    else $error("stopped timer moved or matched");

  AST_LOOP_WRAP: assert property (
    s_r.running && !s_r.one_shot && s_r.tcount == TMR_MAX && !wr_tctrl
    |=> s_r.running && s_r.tcount == 16'h0000)
    else $error("loop timer did not wrap");

  AST_RESTART: assert property (
    clr_edge |=> s_r.running && s_r.tcount == 16'h0000 && !s_r.lock)
    else $error("clear pin edge did not restart timer");

  AST_LOWER_ONLY: assert property (
    o_conv_start && !s_r.internal |-> !o_conv_chan[2])
    else $error("timer trigger converted an upper input");

  AST_IGNORE_OFF: assert property (
    s_r.st == ST_OFF && !wr_mode_a |=> !o_conv_start && s_r.cnt == 4'h0)
    else $error("match acted while disabled");

  AST_ABORT: assert property (
    s_r.st == ST_CONV && (wr_mode_a || wr_mode_b) && !i_conv_done
    |=> o_conv_abort && $stable(s_r.res))
    else $error("mode write did not abort");

  AST_STORE_ON_DONE: assert property (
    !$stable(s_r.res) |-> $past(i_conv_done) && $past(s_r.st) == ST_CONV)
    else $error("result stored without completion");

  AST_BUF4_DONE: assert property (
    s_r.st == ST_CONV && i_conv_done && s_r.buf4 && !s_r.scan &&
    s_r.cnt == 4'h3 && !wr_mode_a && !wr_mode_b
    |=> o_conversion_done_irq && !o_in_progress ##1 !o_conversion_done_irq)
    else $error("fourth buffer conversion raised no done");

  AST_EN_OFF: assert property (
    en_off_wr && !i_conv_done
    |=> s_r.st == ST_OFF && !o_conversion_done_irq && !o_in_progress)
    else $error("enable clear did not go to standby quietly");

  AST_BUSY_SET: assert property (
    $rose(o_in_progress) |-> o_conv_start && $past(s_r.st) == ST_WAIT)
    else $error("busy set without a trigger start");

endmodule

// file: ats_conv_model.sv
// behavioural converter answering start pulses with a done pulse and result
`timescale 1ns/1ps
module ats_conv_model (
  input wire logic i_clock, // clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_start, // start pulse
  input wire logic [2:0] i_chan, // input to convert
  input wire logic i_abort, // drop the running conversion
  input wire logic i_slow, // long conversion time
  output logic o_done, // done pulse
  output logic [9:0] o_result // result, valid with done only
);
  int left;
  logic [6:0] seq;
  logic [9:0] val;
  always @(posedge i_clock) begin
    o_done <= 1'b0;
    // outside done the result lines toggle so a stale value never passes
    o_result <= ~o_result;
    if (i_rst) begin
      left <= 0;
      seq <= 7'h00;
      o_result <= 10'h155;
    end else if (i_abort) begin
      left <= 0;
    end else if (i_start) begin
      left <= i_slow ? 20 : 3;
      val <= {i_chan, seq};
      seq <= seq + 7'h01;
    end else if (left == 1) begin
      left <= 0;
      o_done <= 1'b1;
      o_result <= val;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule

// file: test_adc_timer_trigger_sequencer.sv
// self-checking testbench for the timer-triggered conversion sequencer
`timescale 1ns/1ps
module test_adc_timer_trigger_sequencer;
  import ats_pkg::*;
  logic i_clock, i_rst, hsel, hwrite, clr, slow, hready, hresp;
  logic start, abort, busy, irq, done;
  logic [31:0] haddr, hwdata, hrdata, r, last2;
  logic [1:0] htrans;
  logic [2:0] chan;
  logic [9:0] result;
  logic [2:0] chs[$];
  int errors = 0;
  int check_count = 0;
  int st_cnt = 0;
  int irq_cnt = 0;
  int dn_cnt = 0;
  int ab_cnt = 0;
  int s, i0, a0;
  int ord[4] = '{1, 0, 2, 3};
  int cv[4] = '{25, 10, 40, 55};

  ats_sequencer dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .i_timer_clear_pin(clr),
    .i_conv_done(done), .i_conv_result(result), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .o_conv_start(start),
    .o_conv_chan(chan), .o_conv_abort(abort), .o_in_progress(busy),
    .o_conversion_done_irq(irq));
  ats_conv_model conv_u (.i_clock(i_clock), .i_rst(i_rst), .i_start(start),
    .i_chan(chan), .i_abort(abort), .i_slow(slow), .o_done(done),
    .o_result(result));

  always @(posedge i_clock) begin
    if (start === 1'b1) begin
      st_cnt <= st_cnt + 1;
      chs.push_back(chan);
    end
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (done === 1'b1) dn_cnt <= dn_cnt + 1;
    if (abort === 1'b1) ab_cnt <= ab_cnt + 1;
  end

  task automatic stop_test();
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic int cnt(input int sel);
    case (sel)
      0: return st_cnt;
      1: return irq_cnt;
      2: return dn_cnt;
      default: return ab_cnt;
    endcase
  endfunction
  task automatic waitc(input int sel, input int n);
    int k = 0;
    while (cnt(sel) < n && k < 400) begin
      @(posedge i_clock);
      k++;
    end
    if (k >= 400) begin
      errors++;
      stop_test();
    end
  endtask
  task automatic rdy();
    int n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (n >= 100) begin
      errors++;
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ_BIT;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask
  function automatic logic [31:0] er(input int c, input int i);
    return {22'h0, c[2:0], i[6:0]};
  endfunction
  task automatic rres(input int k, input logic [31:0] e);
    bus(1'b0, OFF_RES0 + 8'(k * 4), 32'h0);
    cmp(r, e);
  endtask
  task automatic snap();
    s = st_cnt;
    i0 = irq_cnt;
  endtask

  task automatic t_reset();
    bus(1'b0, OFF_MODE_A, 32'h0);
    cmp(r, 32'h0);
    bus(1'b0, 8'h44, 32'h0);
    cmp(r, 32'h0);
    cmp(32'(hresp), 32'h0);
    for (int k = 0; k < 4; k++) bus(1'b1, OFF_CMP0 + 8'(k * 4), 32'(cv[k]));
  endtask
  task automatic t_sel1();
    bus(1'b1, OFF_MODE_B, 32'h0);
    bus(1'b1, OFF_MODE_A, 32'h82);
    repeat (2) begin
      snap();
      bus(1'b1, OFF_TCTRL, 32'h1);
      waitc(0, s + 1);
      cmp(32'(chs[s]), 32'h2);
      waitc(1, i0 + 1);
      cmp(32'(busy), 32'h0);
      last2 = er(2, s);
      rres(2, last2);
    end
  endtask
  task automatic t_4b1();
    bus(1'b1, OFF_MODE_A, 32'h89);
    snap();
    for (int k = 0; k < 4; k++) begin
      cmp(irq_cnt, i0);
      bus(1'b1, OFF_TCTRL, 32'h1);
      waitc(2, dn_cnt + 1);
    end
    waitc(1, i0 + 1);
    for (int k = 0; k < 4; k++) rres(k, er(1, s + k));
  endtask
  task automatic t_4b4();
    bus(1'b1, OFF_MODE_B, 32'h1);
    bus(1'b1, OFF_MODE_A, 32'h89);
    snap();
    bus(1'b1, OFF_TCTRL, 32'h3);
    waitc(0, s + 4);
    waitc(1, i0 + 1);
    for (int p = 0; p < 4; p++) rres(ord[p], er(1, s + p));
    cmp(irq_cnt, i0 + 1);
    clr <= 1'b1;
    waitc(0, s + 5);
    cmp(32'(busy), 32'h1);
    clr <= 1'b0;
  endtask
  task automatic t_scan1();
    bus(1'b1, OFF_MODE_B, 32'h0);
    bus(1'b1, OFF_MODE_A, 32'h95);
    snap();
    for (int k = 0; k < 4; k++) begin
      cmp(irq_cnt, i0);
      bus(1'b1, OFF_TCTRL, 32'h1);
      waitc(2, dn_cnt + 1);
    end
    waitc(1, i0 + 1);
    for (int j = 0; j < 6; j++) begin
      cmp(32'(chs[s + j]), 32'(j));
      rres(j, er(j, s + j));
    end
    bus(1'b1, OFF_TCTRL, 32'h1);
    waitc(0, s + 7);
    cmp(32'(chs[s + 6]), 32'h0);
  endtask
  task automatic t_scan4();
    bus(1'b1, OFF_MODE_B, 32'h1);
    bus(1'b1, OFF_MODE_A, 32'h93);
    snap();
    bus(1'b1, OFF_TCTRL, 32'h1);
    waitc(0, s + 4);
    waitc(1, i0 + 1);
    for (int p = 0; p < 4; p++) begin
      cmp(32'(chs[s + p]), 32'(ord[p]));
      rres(ord[p], er(ord[p], s + p));
    end
    bus(1'b1, OFF_TCTRL, 32'h1);
    waitc(0, s + 5);
    cmp(32'(chs[s + 4]), 32'h1);
  endtask
  task automatic t_abort();
    slow <= 1'b1;
    bus(1'b1, OFF_MODE_B, 32'h0);
    bus(1'b1, OFF_MODE_A, 32'h82);
    bus(1'b1, OFF_TCTRL, 32'h1);
    snap();
    a0 = ab_cnt;
    // earlier scenarios refilled result 2, so take its value before the abort
    bus(1'b0, OFF_RES0 + 8'h08, 32'h0);
    last2 = r;
    waitc(0, s + 1);
    bus(1'b1, OFF_MODE_A, 32'h82);
    waitc(3, a0 + 1);
    repeat (40) @(posedge i_clock);
    cmp(irq_cnt, i0);
    rres(2, last2);
    slow <= 1'b0;
  endtask
  task automatic t_off();
    bus(1'b1, OFF_MODE_A, 32'h89);
    bus(1'b1, OFF_TCTRL, 32'h3);
    snap();
    waitc(2, dn_cnt + 1);
    bus(1'b1, OFF_MODE_A, 32'h09);
    bus(1'b1, OFF_TCTRL, 32'h3);
    repeat (60) @(posedge i_clock);
    cmp(st_cnt, s + 1);
    cmp(irq_cnt, i0);
  endtask

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  initial begin
    i_rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    clr = 1'b0;
    slow = 1'b0;
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset();
    t_sel1();
    t_4b1();
    t_4b4();
    t_scan1();
    t_scan4();
    t_abort();
    t_off();
    stop_test();
  end
endmodule
